/* File: core/hotplug_fault_sequencer.sv */
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "hotplug_cfg.svh"

module hotplug_fault_sequencer #(
    parameter int unsigned DEBOUNCE_CYCLES = `HP_DEBOUNCE_CYCLES,
    parameter int unsigned RESET_CYCLES    = `HP_RESET_CYCLES
) (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire hotplug_pkg::comparator_in_t cmp,
    input  wire logic                        latchOffMode,
    output      hotplug_pkg::gate_drive_t    drive,
    output      logic                        faultN,
    input  wire logic [7:0]                  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output      logic                        s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output      logic                        s_axi_wready,
    output      logic [1:0]                  s_axi_bresp,
    output      logic                        s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [7:0]                  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output      logic                        s_axi_arready,
    output      logic [31:0]                 s_axi_rdata,
    output      logic [1:0]                  s_axi_rresp,
    output      logic                        s_axi_rvalid,
    input  wire logic                        s_axi_rready
);
    import hotplug_pkg::*;

    localparam logic [11:0] GLITCH_LAST = 12'(`HP_GLITCH_CYCLES - 1);
    localparam logic [11:0] EXIT_LAST   = 12'(`HP_EXIT_CYCLES - 1);
    localparam logic [24:0] DEB_LAST    = 25'(DEBOUNCE_CYCLES - 1);
    localparam logic [14:0] RST_LAST    = 15'(RESET_CYCLES - 1);
    localparam logic [3:0]  COOL_LAST   = 4'(`HP_COOL_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    logic [1:0]  onRaw;
    logic [1:0]  onFilt_reg;
    logic [11:0] glitchCnt_reg [2];
    logic        onHigh;
    logic        onAboveReset;

    assign onRaw        = {cmp.onAboveReset, cmp.onAboveTh};
    assign onHigh       = onFilt_reg[0];
    assign onAboveReset = onFilt_reg[1];

    // Each ON comparator has its own glitch filter so a brief dip cannot clear a fault.
    for (genvar i = 0; i < 2; i++) begin : g_onFilter
        always_ff @(posedge clk) begin
            if (!resetn) begin
                onFilt_reg[i]    <= 1'b0;
                glitchCnt_reg[i] <= 12'h000;
            end else if (onRaw[i] == onFilt_reg[i]) begin
                glitchCnt_reg[i] <= 12'h000;
            end else if (glitchCnt_reg[i] == GLITCH_LAST) begin
                onFilt_reg[i]    <= onRaw[i];
                glitchCnt_reg[i] <= 12'h000;
            end else begin
                glitchCnt_reg[i] <= glitchCnt_reg[i] + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    gate_state_t gate_reg;
    tmr_state_t  tmr_reg;
    logic        fault_reg;
    logic        debounced_reg;
    logic [24:0] debCnt_reg;
    logic        debDone;
    logic [14:0] rstCnt_reg;
    logic        onReset;
    logic [3:0]  cool_reg;
    logic [11:0] exitCnt_reg;
    logic [31:0] ctrl_reg;
    logic        trip;
    logic        coolEnd;
    logic        startOk;
    logic        supply_lockout;
    logic        softOff;

    assign supply_lockout    = cmp.supplyLockout;
    assign softOff = ctrl_reg[`HP_CTRL_SOFT_OFF];
    assign trip    = (tmr_reg == TMR_FILTER) && (gate_reg != GATE_OFF)
                     && (gate_reg != GATE_LOCK) && cmp.timerAboveUpper;
    assign coolEnd = (tmr_reg == TMR_COOL_DOWN) && !cmp.timerAboveLower
                     && (cool_reg == COOL_LAST);
    assign debDone = onHigh && !cmp.enableNHigh && !debounced_reg && (debCnt_reg == DEB_LAST);
    assign onReset = !onAboveReset && (rstCnt_reg == RST_LAST);
    assign startOk = onHigh && debounced_reg && !cmp.enableNHigh && !fault_reg
                     && (tmr_reg == TMR_FILTER) && !softOff;

    // Debounce only runs with filtered ON high and enable-n low; any enable-n bounce zeroes it.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            debCnt_reg <= 25'h0000000;
        end else if (supply_lockout || !onHigh || cmp.enableNHigh || debounced_reg) begin
            debCnt_reg <= 25'h0000000;
        end else begin
            debCnt_reg <= debCnt_reg + 25'h0000001;
        end
    end

    // Kept through an ON undervoltage so the gate returns without a new debounce.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            debounced_reg <= 1'b0;
        end else if (supply_lockout || !onAboveReset || cmp.enableNHigh) begin
            debounced_reg <= 1'b0;
        end else if (debDone) begin
            debounced_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rstCnt_reg <= 15'h0000;
        end else if (onAboveReset) begin
            rstCnt_reg <= 15'h0000;
        end else if (rstCnt_reg != RST_LAST) begin
            rstCnt_reg <= rstCnt_reg + 15'h0001;
        end
    end

    // A trip in the same cycle as any clear except supply lockout keeps the fault latched.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            fault_reg <= 1'b0;
        end else if (supply_lockout) begin
            fault_reg <= 1'b0;
        end else if (trip) begin
            fault_reg <= 1'b1;
        end else if (onReset || debDone) begin
            fault_reg <= 1'b0;
        end else if (coolEnd && !latchOffMode) begin
            fault_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!resetn || supply_lockout) begin
            tmr_reg  <= TMR_FILTER;
            cool_reg <= 4'h0;
        end else begin
            unique case (tmr_reg)
                TMR_FILTER: begin
                    if (trip) begin
                        tmr_reg <= TMR_DRAIN;
                    end
                end
                TMR_DRAIN: begin
                    if (!cmp.timerAboveLower) begin
                        tmr_reg  <= TMR_COOL_UP;
                        cool_reg <= 4'h0;
                    end
                end
                TMR_COOL_UP: begin
                    if (cmp.timerAboveUpper) begin
                        tmr_reg <= TMR_COOL_DOWN;
                    end
                end
                TMR_COOL_DOWN: begin
                    if (!cmp.timerAboveLower) begin
                        if (cool_reg != COOL_LAST) begin
                            cool_reg <= cool_reg + 4'h1;
                            tmr_reg  <= TMR_COOL_UP;
                        end else if (!latchOffMode || !fault_reg) begin
                            tmr_reg <= TMR_FILTER;
                        end else begin
                            tmr_reg <= TMR_COOL_UP;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!resetn) begin
            gate_reg    <= GATE_LOCK;
            exitCnt_reg <= 12'h000;
        end else if (supply_lockout) begin
            gate_reg    <= GATE_LOCK;
            exitCnt_reg <= 12'h000;
        end else begin
            unique case (gate_reg)
                GATE_LOCK: begin
                    gate_reg <= GATE_OFF;
                end
                GATE_OFF: begin
                    if (startOk) begin
                        gate_reg <= GATE_ON;
                    end
                end
                GATE_ON: begin
                    if (trip || !onHigh || softOff) begin
                        gate_reg <= GATE_OFF;
                    end else if (cmp.enableNHigh) begin
                        gate_reg    <= GATE_EXIT;
                        exitCnt_reg <= 12'h000;
                    end
                end
                GATE_EXIT: begin
                    if (trip || !onHigh || softOff || exitCnt_reg == EXIT_LAST) begin
                        gate_reg <= GATE_OFF;
                    end else begin
                        exitCnt_reg <= exitCnt_reg + 12'h001;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Diode drive never looks at the fault or gate state.
    gate_drive_t drive_reg;
    logic        faultN_reg;
    logic        gateUp;

    assign gateUp = (gate_reg == GATE_ON) || (gate_reg == GATE_EXIT);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            drive_reg  <= '0;
            faultN_reg <= 1'b1;
        end else begin
            drive_reg.hotPlugGateCharge     <= gateUp && !supply_lockout && !trip;
            drive_reg.hotPlugGateSinkNormal <= !gateUp && !supply_lockout;
            drive_reg.hotPlugGateSinkStrong <= supply_lockout || trip || (tmr_reg == TMR_DRAIN);
            drive_reg.currentLimitAmpOn     <= gateUp && cmp.senseAboveLimit;
            drive_reg.diodeGateEnable[0]    <= !supply_lockout;
            drive_reg.diodeGateEnable[1]    <= !supply_lockout && !cmp.secondDiodeDisable;
            drive_reg.diodeGateWeakSink[0]  <= supply_lockout;
            drive_reg.diodeGateWeakSink[1]  <= supply_lockout || cmp.secondDiodeDisable;
            drive_reg.diodeGateFastPulldown <= supply_lockout ? 2'h0 : cmp.diodeReverse;
            drive_reg.timerPullUp           <= !supply_lockout && ((tmr_reg == TMR_COOL_UP)
                                               || (tmr_reg == TMR_FILTER && cmp.senseAboveBreaker));
            drive_reg.timerPullDown         <= supply_lockout || (tmr_reg == TMR_DRAIN) || (tmr_reg == TMR_COOL_DOWN)
                                               || (tmr_reg == TMR_FILTER && !cmp.senseAboveBreaker);
            faultN_reg <= !(fault_reg || trip) || supply_lockout;
        end
    end

    assign drive  = drive_reg;
    assign faultN = faultN_reg;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave; address and data are latched separately so order is free.
    logic        awHave_reg;
    logic        wHave_reg;
    logic [7:0]  awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0]  wStrb_reg;
    logic        awReady_reg;
    logic        wReady_reg;
    logic        bValid_reg;
    logic [1:0]  bResp_reg;
    logic        arReady_reg;
    logic        rValid_reg;
    logic [1:0]  rResp_reg;
    logic [31:0] rData_reg;
    logic        wrGo;
    logic [31:0] status;

    assign wrGo = awHave_reg && wHave_reg && !bValid_reg;

    always_comb begin
        status                                  = 32'h0000_0000;
        status[`HP_ST_FAULT]                    = fault_reg;
        status[`HP_ST_DEBOUNCED]                = debounced_reg;
        status[`HP_ST_GATE +: 2]                = gate_reg;
        status[`HP_ST_TMR +: 2]                 = tmr_reg;
        status[`HP_ST_COOL +: 4]                = cool_reg;
        status[`HP_ST_ON +: 2]                  = onFilt_reg;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            awHave_reg  <= 1'b0;
            awAddr_reg  <= 8'h00;
            awReady_reg <= 1'b0;
        end else if (s_axi_awvalid && awReady_reg) begin
            awHave_reg  <= 1'b1;
            awAddr_reg  <= s_axi_awaddr;
            awReady_reg <= 1'b0;
        end else begin
            if (wrGo) begin
                awHave_reg <= 1'b0;
            end
            awReady_reg <= !awHave_reg && !awReady_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wHave_reg  <= 1'b0;
            wData_reg  <= 32'h0000_0000;
            wStrb_reg  <= 4'h0;
            wReady_reg <= 1'b0;
        end else if (s_axi_wvalid && wReady_reg) begin
            wHave_reg  <= 1'b1;
            wData_reg  <= s_axi_wdata;
            wStrb_reg  <= s_axi_wstrb;
            wReady_reg <= 1'b0;
        end else begin
            if (wrGo) begin
                wHave_reg <= 1'b0;
            end
            wReady_reg <= !wHave_reg && !wReady_reg;
        end
    end

    // Status writes are accepted and dropped; only unmapped addresses error.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_reg   <= `HP_CTRL_RESET;
            bValid_reg <= 1'b0;
            bResp_reg  <= `HP_RESP_OKAY;
        end else if (wrGo) begin
            bValid_reg <= 1'b1;
            bResp_reg  <= `HP_RESP_OKAY;
            if (awAddr_reg == `HP_ADDR_CTRL) begin
                for (int b = 0; b < 4; b++) begin
                    if (wStrb_reg[b]) begin
                        ctrl_reg[b*8 +: 8] <= wData_reg[b*8 +: 8];
                    end
                end
            end else if (awAddr_reg != `HP_ADDR_STATUS) begin
                bResp_reg <= `HP_RESP_SLVERR;
            end
        end else if (bValid_reg && s_axi_bready) begin
            bValid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            arReady_reg <= 1'b0;
            rValid_reg  <= 1'b0;
            rResp_reg   <= `HP_RESP_OKAY;
            rData_reg   <= 32'h0000_0000;
        end else if (s_axi_arvalid && arReady_reg) begin
            arReady_reg <= 1'b0;
            rValid_reg  <= 1'b1;
            rResp_reg   <= `HP_RESP_OKAY;
            if (s_axi_araddr == `HP_ADDR_CTRL) begin
                rData_reg <= ctrl_reg;
            end else if (s_axi_araddr == `HP_ADDR_STATUS) begin
                rData_reg <= status;
            end else begin
                rData_reg <= 32'h0000_0000;
                rResp_reg <= `HP_RESP_SLVERR;
            end
        end else if (rValid_reg) begin
            if (s_axi_rready) begin
                rValid_reg <= 1'b0;
            end
        end else begin
            arReady_reg <= !arReady_reg;
        end
    end

    assign s_axi_awready = awReady_reg;
    assign s_axi_wready  = wReady_reg;
    assign s_axi_bvalid  = bValid_reg;
    assign s_axi_bresp   = bResp_reg;
    assign s_axi_arready = arReady_reg;
    assign s_axi_rvalid  = rValid_reg;
    assign s_axi_rresp   = rResp_reg;
    assign s_axi_rdata   = rData_reg;
endmodule

/* File: include/hotplug_cfg.svh */
`ifndef HOTPLUG_CFG_SVH
`define HOTPLUG_CFG_SVH
`define HP_CLK_MHZ          200
`define HP_GLITCH_US        10
`define HP_GLITCH_CYCLES    (`HP_GLITCH_US * `HP_CLK_MHZ)
`define HP_EXIT_US          20
`define HP_EXIT_CYCLES      (`HP_EXIT_US * `HP_CLK_MHZ)
`define HP_DEBOUNCE_MS      100
`define HP_DEBOUNCE_CYCLES  (`HP_DEBOUNCE_MS * 1000 * `HP_CLK_MHZ)
`define HP_RESET_HOLD_US    100
`define HP_RESET_CYCLES     (`HP_RESET_HOLD_US * `HP_CLK_MHZ)
`define HP_COOL_CYCLES      14
`define HP_ADDR_CTRL        8'h00
`define HP_ADDR_STATUS      8'h04
`define HP_CTRL_RESET       32'h0000_0000
`define HP_CTRL_SOFT_OFF    0
`define HP_ST_FAULT         0
`define HP_ST_DEBOUNCED     1
`define HP_ST_GATE          2
`define HP_ST_TMR           4
`define HP_ST_COOL          8
`define HP_ST_ON            12
`define HP_RESP_OKAY        2'h0
`define HP_RESP_SLVERR      2'h2
`endif

/* File: include/hotplug_pkg.sv */
package hotplug_pkg;
    typedef struct packed {
        logic       onAboveTh;
        logic       onAboveReset;
        logic       enableNHigh;
        logic       secondDiodeDisable;
        logic       senseAboveBreaker;
        logic       senseAboveLimit;
        logic       timerAboveUpper;
        logic       timerAboveLower;
        logic       supplyLockout;
        logic [1:0] diodeReverse;
    } comparator_in_t;

    typedef struct packed {
        logic       hotPlugGateCharge;
        logic       hotPlugGateSinkNormal;
        logic       hotPlugGateSinkStrong;
        logic       currentLimitAmpOn;
        logic [1:0] diodeGateEnable;
        logic [1:0] diodeGateWeakSink;
        logic [1:0] diodeGateFastPulldown;
        logic       timerPullUp;
        logic       timerPullDown;
    } gate_drive_t;

    typedef enum logic [1:0] {
        GATE_OFF  = 2'b00,
        GATE_ON   = 2'b01,
        GATE_EXIT = 2'b10,
        GATE_LOCK = 2'b11
    } gate_state_t;

    typedef enum logic [1:0] {
        TMR_FILTER    = 2'b00,
        TMR_DRAIN     = 2'b01,
        TMR_COOL_UP   = 2'b10,
        TMR_COOL_DOWN = 2'b11
    } tmr_state_t;
endpackage

/* File: tb/hotplug_fault_sequencer_props.sv */
`timescale 1ns/1ps
module hotplug_fault_sequencer_props (
    input wire logic                        clk,
    input wire logic                        resetn,
    input wire hotplug_pkg::comparator_in_t cmp,
    input wire hotplug_pkg::gate_drive_t    drive,
    input wire logic                        faultN
);
    import hotplug_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////////
    chk_lock_gate: assert property (cmp.supplyLockout [*2] |=> drive.hotPlugGateSinkStrong &&
        !drive.hotPlugGateCharge && drive.diodeGateEnable == 2'b00 && drive.diodeGateWeakSink == 2'b11)
        else $error("lockout left a switch on");
    chk_lock_fault: assert property (cmp.supplyLockout [*2] |=> faultN)
        else $error("lockout kept the fault flag");
    chk_second_off: assert property (cmp.secondDiodeDisable [*2] |=>
        !drive.diodeGateEnable[1] && drive.diodeGateWeakSink[1])
        else $error("second diode gate not sunk");
    chk_fast_pull: assert property ((cmp.diodeReverse[0] && !cmp.supplyLockout) [*2] |=>
        drive.diodeGateFastPulldown[0])
        else $error("reverse detect without fast pull-down");
    chk_timer_up: assert property ((faultN && drive.hotPlugGateCharge && cmp.senseAboveBreaker &&
        !cmp.timerAboveUpper) [*2] |=> drive.timerPullUp && !drive.timerPullDown)
        else $error("timer not charged during overcurrent");
    chk_trip_fault: assert property (drive.hotPlugGateCharge && cmp.timerAboveUpper && !cmp.supplyLockout
        |-> ##[1:3] (!faultN && drive.hotPlugGateSinkStrong && !drive.hotPlugGateCharge))
        else $error("timer threshold did not trip");
    chk_diode_keep: assert property ((!faultN && !cmp.supplyLockout && !cmp.secondDiodeDisable &&
        !cmp.diodeReverse[0]) [*2] |=> drive.diodeGateEnable[0])
        else $error("fault turned a diode off");
    chk_exit_wait: assert property ($rose(cmp.enableNHigh) && drive.hotPlugGateCharge && cmp.onAboveTh &&
        !cmp.supplyLockout |=> (drive.hotPlugGateCharge && !drive.hotPlugGateSinkNormal) [*8])
        else $error("removal turned gate off too early");
    chk_latch_hold: assert property (!faultN ##1 !faultN |-> !drive.hotPlugGateCharge)
        else $error("gate charged while fault latched");
    chk_limit_amp: assert property (drive.hotPlugGateCharge && $past(cmp.senseAboveLimit) |->
        drive.currentLimitAmpOn)
        else $error("current limit amplifier not engaged");
    cov_trip: cover property ($fell(faultN));
    cov_release: cover property ($rose(faultN) && !cmp.supplyLockout);
    cov_start: cover property ($rose(drive.hotPlugGateCharge));
endmodule

bind hotplug_fault_sequencer hotplug_fault_sequencer_props chkInst (
    .clk(clk), .resetn(resetn), .cmp(cmp), .drive(drive), .faultN(faultN));

/* File: tb/power_stage_model.sv */
`timescale 1ns/1ps
module power_stage_model (
    input  wire logic                     clk,
    input  wire hotplug_pkg::gate_drive_t drive,
    input  wire logic                     shortLoad,
    output      logic                     overBreaker,
    output      logic                     timerHigh,
    output      logic                     timerLow
);
    import hotplug_pkg::*;
    int level = 0;
    // Charging is five times faster than draining, so each cooling cycle is long and the count shows.
    always @(posedge clk) begin
        if (drive.timerPullUp && level < 60) begin
            level <= level + 5;
        end else if (drive.timerPullDown && level > 0) begin
            level <= level - 1;
        end
    end
    // A short only draws current while the pass switch is being driven on.
    assign overBreaker = shortLoad && drive.hotPlugGateCharge;
    assign timerHigh   = level > 40;
    assign timerLow    = level > 8;
endmodule

/* File: tb/hotplug_fault_sequencer_test.sv */
`timescale 1ns/1ps
`include "hotplug_cfg.svh"
module hotplug_fault_sequencer_test;
    import hotplug_pkg::*;
    typedef struct packed {
        logic       d2;
        logic [1:0] rev;
        logic       lock;
        logic [5:0] exp;
        logic [5:0] mask;
    } row_t;
    localparam int DEB = 50;
    localparam int RST = 20;
    logic           clk = 1'b0;
    logic           resetn = 1'b0;
    logic           latchOffMode = 1'b1;
    logic           shortLoad = 1'b0;
    comparator_in_t cmpDrv = '0;
    comparator_in_t cmp;
    gate_drive_t    drive;
    logic           faultN, overBreaker, timerHigh, timerLow;
    logic [7:0]     s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]    s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [1:0]     s_axi_bresp, s_axi_rresp, rs;
    logic           s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int             n_fail = 0, check_count = 0, n;
    row_t           rows [5] = '{'{1'b0, 2'b00, 1'b0, 6'h30, 6'h3C}, '{1'b1, 2'b00, 1'b0, 6'h18, 6'h3C},
        '{1'b0, 2'b01, 1'b0, 6'h01, 6'h03}, '{1'b0, 2'b10, 1'b0, 6'h02, 6'h03}, '{1'b0, 2'b00, 1'b1, 6'h0C, 6'h3C}};
    ////////////////////////////////////////////////////////////////////////////////
    always #2.5 clk = ~clk;
    always_comb begin
        cmp = cmpDrv;
        cmp.senseAboveBreaker = overBreaker;
        cmp.senseAboveLimit = overBreaker;
        cmp.timerAboveUpper = timerHigh;
        cmp.timerAboveLower = timerLow;
    end
    hotplug_fault_sequencer #(.DEBOUNCE_CYCLES(DEB), .RESET_CYCLES(RST)) uut (.clk, .resetn, .cmp, .latchOffMode,
        .drive, .faultN, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    power_stage_model stage (.clk, .drive, .shortLoad, .overBreaker, .timerHigh, .timerLow);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    function automatic logic cond(input int k);
        case (k)
            0: return drive.hotPlugGateCharge;
            1: return !faultN;
            2: return faultN;
            default: return drive.hotPlugGateSinkNormal;
        endcase
    endfunction
    task automatic waitOn(input int k, input int lim, output int cnt);
        cnt = 0;
        while (cond(k) !== 1'b1) begin
            @(posedge clk);
            cnt++;
            if (cnt > lim) begin
                check("wait bound", 32'(k), 32'hFFFF);
                report_and_stop();
            end
        end
    endtask
    // Address and data go out together; bready or rready stays high until the answer is sampled.
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= wd;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        do begin
            @(posedge clk);
            k++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            rd = s_axi_rdata;
            rs = wr ? s_axi_bresp : s_axi_rresp;
        end while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && k < 50);
        // Only the channel in use is released, so a following call may raise the other at once.
        if (wr) s_axi_bready <= 1'b0;
        else s_axi_rready <= 1'b0;
        check("bus answer", 32'(k < 50), 32'h1);
        if (k >= 50) report_and_stop();
    endtask
    task automatic setOn(input logic v);
        cmpDrv.onAboveTh <= v;
        cmpDrv.onAboveReset <= v;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        check("reset outputs", 32'({drive, faultN}), 32'h1);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            cmpDrv.secondDiodeDisable <= rows[i].d2;
            cmpDrv.diodeReverse <= rows[i].rev;
            cmpDrv.supplyLockout <= rows[i].lock;
            repeat (4) @(posedge clk);
            check("diode row", 32'({drive.diodeGateEnable, drive.diodeGateWeakSink,
                drive.diodeGateFastPulldown} & rows[i].mask), 32'(rows[i].exp));
        end
        cmpDrv <= '{onAboveTh: 1'b1, onAboveReset: 1'b1, default: '0};
        repeat (2040) @(posedge clk);
        cmpDrv.enableNHigh <= 1'b1;
        @(posedge clk);
        cmpDrv.enableNHigh <= 1'b0;
        waitOn(0, 200, n);
        check("debounce restart", 32'(n >= DEB), 32'h1);
        setOn(1'b0);
        repeat (100) @(posedge clk);
        setOn(1'b1);
        repeat (10) @(posedge clk);
        check("on glitch", 32'(drive.hotPlugGateCharge), 32'h1);
        cmpDrv.enableNHigh <= 1'b1;
        waitOn(3, 4100, n);
        check("removal delay", 32'(n > 3990 && n < 4010), 32'h1);
        cmpDrv.enableNHigh <= 1'b0;
        waitOn(0, 200, n);
        shortLoad <= 1'b1;
        waitOn(1, 200, n);
        check("trip", 32'({drive.diodeGateEnable, drive.hotPlugGateCharge}), 32'h6);
        shortLoad <= 1'b0;
        repeat (3000) @(posedge clk);
        check("latched", 32'({faultN, drive.hotPlugGateCharge}), 32'h0);
        axi(1'b0, `HP_ADDR_STATUS, 32'h0);
        check("status", 32'({rs, rd[11:8], rd[0]}), 32'h1B);
        setOn(1'b0);
        waitOn(2, 2100, n);
        check("on reset hold", 32'(n >= 2000 + RST - 5), 32'h1);
        repeat (50) @(posedge clk);
        setOn(1'b1);
        waitOn(0, 2200, n);
        check("debounce after reset", 32'(n >= 2000 + DEB - 5), 32'h1);
        resetn <= 1'b0;
        latchOffMode <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        waitOn(0, 2200, n);
        shortLoad <= 1'b1;
        waitOn(1, 200, n);
        shortLoad <= 1'b0;
        waitOn(2, 3000, n);
        check("cool-off length", 32'(n > 400), 32'h1);
        waitOn(0, 20, n);
        axi(1'b1, `HP_ADDR_CTRL, 32'h1);
        check("ctrl write", 32'(rs), 32'h0);
        repeat (5) @(posedge clk);
        check("soft off", 32'(drive.hotPlugGateCharge), 32'h0);
        axi(1'b0, 8'h10, 32'h0);
        check("unmapped", 32'({rs, rd[29:0]}), 32'h80000000);
        axi(1'b1, `HP_ADDR_CTRL, 32'h0);
        cmpDrv.supplyLockout <= 1'b1;
        repeat (4) @(posedge clk);
        cmpDrv.supplyLockout <= 1'b0;
        waitOn(0, 2200, n);
        check("lockout debounce", 32'(n >= DEB - 5), 32'h1);
        report_and_stop();
    end
endmodule
